// *** shared/icp_consts.svh ***
// constant definitions for the interactive command port
`ifndef ICP_CONSTS_SVH
`define ICP_CONSTS_SVH

// framing, separator, digit and command letter characters
`define ICP_CH_LF 8'h0a
`define ICP_CH_TAB 8'h09
`define ICP_CH_CR 8'h0d
`define ICP_CH_SPACE 8'h20
`define ICP_CH_DOT 8'h2e
`define ICP_CH_ZERO 8'h30
`define ICP_CH_A_UP 8'h41
`define ICP_CH_A_LO 8'h61
`define ICP_CH_T_UP 8'h54
`define ICP_CH_T_LO 8'h74
`define ICP_CH_I_UP 8'h49
`define ICP_CH_I_LO 8'h69

// two-digit status fields, first and second character
`define ICP_STAT_OK 16'h3030
`define ICP_STAT_FAIL 16'h3031
`define ICP_STAT_INFO 16'h3130

// error result codes sent in failure lines
`define ICP_ERR_SYNTAX 8'h01
`define ICP_ERR_MISSING_ARG 8'h02
`define ICP_ERR_RANGE 8'h03

// selector codes of the information query
`define ICP_SEL_NAME 16'h0000
`define ICP_SEL_VERSION 16'h0003
`define ICP_SEL_ADDRESS 16'h0004
`define ICP_SEL_CHIPSET 16'h0005
`define ICP_SEL_DATA_STATS 16'h0006
`define ICP_SEL_FAT_STATS 16'h0007
`define ICP_SEL_LAST_ERR 16'h000c

// selector limit and field sizes
`define ICP_SEL_MAX 20'h0ffff
`define ICP_ECHO_MAX 3'h5
`define ICP_NAME_LEN 5'h08
`define ICP_ADDR_LEN 5'h0f
`define ICP_STATS_LEN 5'h0e
`define ICP_ERR_LEN 5'h02

`endif

// *** shared/icp_pkg.sv ***
// types shared by the interactive command port files
package icp_pkg;

	// reply framing sequencer states
	typedef enum logic [3:0] {
		ST_RECV,
		ST_LF1,
		ST_STAT,
		ST_TAB1,
		ST_ECHO,
		ST_TAB2,
		ST_INFO,
		ST_HEX,
		ST_CR1,
		ST_LF2,
		ST_OK,
		ST_CR2
	} reply_state_e;

	// kind of reply that a completed command line produces
	typedef enum logic [1:0] {
		KIND_OK,
		KIND_FAIL,
		KIND_INFO
	} reply_kind_e;

	typedef logic [7:0] char_t;

endpackage : icp_pkg

// *** verilog/info_text_source.sv ***
// character source for the information query text
`timescale 1ns/1ps
`include "icp_consts.svh"

module info_text_source #(
	parameter logic [63:0] DEV_NAME = 64'h4943_5044_4556_3031,
	parameter logic [63:0] FW_VERSION = 64'h312e_302e_302e_3030,
	parameter logic [63:0] CHIP_NAME = 64'h4348_4950_5345_5430,
	parameter logic [63:0] MAKER_NAME = 64'h4d41_4b45_524e_414d
) (
	input wire logic [15:0] selector,
	input wire logic [4:0] index,
	input wire logic [1:0] addrType,
	input wire logic [47:0] macAddr,
	input wire logic [15:0] dataTotal,
	input wire logic [15:0] dataFree,
	input wire logic [15:0] dataDeleted,
	input wire logic [15:0] fatTotal,
	input wire logic [15:0] fatFree,
	input wire logic [15:0] fatDeleted,
	input wire logic [7:0] lastErr,
	output icp_pkg::char_t infoByte,
	output logic [4:0] infoLen
);

	// upper case ascii for one nibble
	function automatic icp_pkg::char_t hexChar(input logic [3:0] nib);
		hexChar = (nib < 4'ha) ? (`ICP_CH_ZERO + {4'h0, nib}) : (8'h37 + {4'h0, nib});
	endfunction : hexChar

	// byte k of an eight character name, first character in the top byte
	function automatic icp_pkg::char_t nameChar(input logic [63:0] name, input logic [4:0] k);
		nameChar = name[(7 - k[2:0]) * 8 +: 8];
	endfunction : nameChar

	// total.free.deleted as three groups of four hex digits
	function automatic icp_pkg::char_t statChar(input logic [47:0] s, input logic [4:0] k);
		logic [4:0] grp;
		logic [4:0] pos;
		grp = k / 5'h05;
		pos = k - grp * 5'h05;
		if (pos == 5'h04) begin
			statChar = `ICP_CH_DOT;
		end else begin
			statChar = hexChar(s[(2 - grp[1:0]) * 16 + (3 - pos[1:0]) * 4 +: 4]);
		end
	endfunction : statChar

	logic [3:0] macNib;
	logic [3:0] macDigit;

	// mac digits are sent most significant first
	assign macDigit = 4'(index - 5'h03);
	assign macNib = macAddr[(4'hb - macDigit) * 4 +: 4];

	// select the text of the requested selector
	always_comb begin
		infoByte = 8'h00;
		infoLen = `ICP_NAME_LEN;
		unique case (selector)
			`ICP_SEL_NAME: infoByte = nameChar(DEV_NAME, index);
			`ICP_SEL_VERSION: infoByte = nameChar(FW_VERSION, index);
			`ICP_SEL_CHIPSET: infoByte = nameChar(CHIP_NAME, index);
			`ICP_SEL_ADDRESS: begin
				// type field, separator, then twelve hex digits
				infoLen = `ICP_ADDR_LEN;
				if (index == 5'h00) begin
					infoByte = `ICP_CH_ZERO;
				end else if (index == 5'h01) begin
					infoByte = `ICP_CH_ZERO + {6'h00, addrType};
				end else if (index == 5'h02) begin
					infoByte = `ICP_CH_SPACE;
				end else begin
					infoByte = hexChar(macNib);
				end
			end
			`ICP_SEL_DATA_STATS: begin
				infoLen = `ICP_STATS_LEN;
				infoByte = statChar({dataTotal, dataFree, dataDeleted}, index);
			end
			`ICP_SEL_FAT_STATS: begin
				infoLen = `ICP_STATS_LEN;
				infoByte = statChar({fatTotal, fatFree, fatDeleted}, index);
			end
			`ICP_SEL_LAST_ERR: begin
				infoLen = `ICP_ERR_LEN;
				infoByte = hexChar(index[0] ? lastErr[3:0] : lastErr[7:4]);
			end
			default: infoByte = nameChar(MAKER_NAME, index);
		endcase
	end

endmodule : info_text_source

// *** verilog/interactive_command_port.sv ***
// command line interpreter with framed replies over a byte stream
//
// Behaviour
// - tokens of a command line are separated by spaces; runs of spaces collapse
// - each reply line is linefeed, text, carriage return; replies may span lines
// - linefeed is 0x0a, tab is 0x09, carriage return is 0x0d
// - success ends the reply with a line holding only 00
// - failure line holds 01, tab, hex error code, carriage return
// - failure lines carry no explanatory text and no trailing tab
// - hex field of a failure line is the numeric error result code
// - nothing is executed until the terminating carriage return arrives
// - bare prefix command only answers the success line
// - query answers 10, tab, selector echo, tab, text, then success line
// - selector must lie in 0 to 65535; larger values fail
// - selectors 0, 3, 5 give device name, firmware version, chipset name
// - selector 4 gives address type field, separator, then the mac address
// - selectors 6 and 7 give data and table segment space statistics
// - idle waiting for input is flagged as the lowest power state
// - status field of every line is exactly two decimal digits
// - address type codes 00 public, 01 static, 02 resolvable, 03 non-resolvable
`timescale 1ns/1ps
`include "icp_consts.svh"

module interactive_command_port (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	output logic rxReady,
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady,
	input wire logic [1:0] addrType,
	input wire logic [47:0] macAddr,
	input wire logic [15:0] dataTotal,
	input wire logic [15:0] dataFree,
	input wire logic [15:0] dataDeleted,
	input wire logic [15:0] fatTotal,
	input wire logic [15:0] fatFree,
	input wire logic [15:0] fatDeleted,
	output logic lowPower
);

	////////////////////////////////////////////////////////////////////////
	// state

	icp_pkg::reply_state_e state_r, state_nxt;
	icp_pkg::reply_kind_e kind_r, kind_nxt;
	logic [4:0] idx_r, idx_nxt;
	logic [1:0] tokIdx_r, tokIdx_nxt;
	logic [2:0] tokLen_r, tokLen_nxt;
	logic bad_r, bad_nxt;
	logic over_r, over_nxt;
	logic [19:0] acc_r, acc_nxt;
	icp_pkg::char_t echo_r [5];
	icp_pkg::char_t echo_nxt [5];
	logic [2:0] echoLen_r, echoLen_nxt;
	logic [15:0] sel_r, sel_nxt;
	logic [7:0] errCode_r, errCode_nxt;
	logic [7:0] lastErr_r, lastErr_nxt;
	logic [7:0] txData_r, txData_nxt;
	logic txValid_r, txValid_nxt;

	icp_pkg::char_t infoByte;
	logic [4:0] infoLen;
	icp_pkg::char_t curByte;
	logic [15:0] statChars;
	logic [1:0] nTok;
	logic rxTake;
	logic loadSlot;
	logic isDigit;
	logic isA;
	logic isT;
	logic isI;
	logic tok0Short;
	logic [19:0] accMul;

	////////////////////////////////////////////////////////////////////////
	// information text lookup

	info_text_source u_info (
		.selector(sel_r),
		.index(idx_r),
		.addrType(addrType),
		.macAddr(macAddr),
		.dataTotal(dataTotal),
		.dataFree(dataFree),
		.dataDeleted(dataDeleted),
		.fatTotal(fatTotal),
		.fatFree(fatFree),
		.fatDeleted(fatDeleted),
		.lastErr(lastErr_r),
		.infoByte(infoByte),
		.infoLen(infoLen)
	);

	////////////////////////////////////////////////////////////////////////
	// character classes and handshakes

	// input is refused while a reply is going out, so no line is lost
	assign rxReady = (state_r == icp_pkg::ST_RECV);
	assign rxTake = rxValid && rxReady;
	assign loadSlot = !txValid_r || txReady;
	assign isDigit = (rxData >= `ICP_CH_ZERO) && (rxData <= 8'h39);
	assign isA = (rxData == `ICP_CH_A_UP) || (rxData == `ICP_CH_A_LO);
	assign isT = (rxData == `ICP_CH_T_UP) || (rxData == `ICP_CH_T_LO);
	assign isI = (rxData == `ICP_CH_I_UP) || (rxData == `ICP_CH_I_LO);
	assign tok0Short = (tokIdx_r == 2'h0) && (tokLen_r == 3'h1);
	assign nTok = (tokIdx_r == 2'h3) ? 2'h3 : tokIdx_r + {1'b0, (tokLen_r != 3'h0)};
	assign accMul = (acc_r << 3) + (acc_r << 1);

	// idle with nothing pending or in flight
	assign lowPower = rxReady && !rxValid && !txValid_r;
	assign txData = txData_r;
	assign txValid = txValid_r;

	// status field of the first line, always two digits
	always_comb begin
		statChars = `ICP_STAT_OK;
		unique case (kind_r)
			icp_pkg::KIND_OK: statChars = `ICP_STAT_OK;
			icp_pkg::KIND_FAIL: statChars = `ICP_STAT_FAIL;
			icp_pkg::KIND_INFO: statChars = `ICP_STAT_INFO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// byte that the current sequencer step emits

	always_comb begin
		curByte = `ICP_CH_CR;
		unique case (state_r)
			icp_pkg::ST_RECV: curByte = `ICP_CH_CR;
			icp_pkg::ST_LF1: curByte = `ICP_CH_LF;
			icp_pkg::ST_LF2: curByte = `ICP_CH_LF;
			icp_pkg::ST_STAT: curByte = idx_r[0] ? statChars[7:0] : statChars[15:8];
			icp_pkg::ST_TAB1: curByte = `ICP_CH_TAB;
			icp_pkg::ST_TAB2: curByte = `ICP_CH_TAB;
			icp_pkg::ST_ECHO: curByte = echo_r[idx_r[2:0]];
			icp_pkg::ST_INFO: curByte = infoByte;
			icp_pkg::ST_HEX: curByte = idx_r[0] ? errCode_r[3:0] + ((errCode_r[3:0] < 4'ha) ? 8'h30 : 8'h37)
				: errCode_r[7:4] + ((errCode_r[7:4] < 4'ha) ? 8'h30 : 8'h37);
			icp_pkg::ST_CR1: curByte = `ICP_CH_CR;
			icp_pkg::ST_CR2: curByte = `ICP_CH_CR;
			icp_pkg::ST_OK: curByte = `ICP_CH_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// parser and reply sequencer next values

	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		idx_nxt = idx_r;
		tokIdx_nxt = tokIdx_r;
		tokLen_nxt = tokLen_r;
		bad_nxt = bad_r;
		over_nxt = over_r;
		acc_nxt = acc_r;
		echo_nxt = echo_r;
		echoLen_nxt = echoLen_r;
		sel_nxt = sel_r;
		errCode_nxt = errCode_r;
		lastErr_nxt = lastErr_r;
		txData_nxt = txData_r;
		txValid_nxt = txValid_r && !txReady;
		if (rxTake) begin
			if (rxData == `ICP_CH_CR) begin
				// a line is only acted on at its carriage return
				tokIdx_nxt = 2'h0;
				tokLen_nxt = 3'h0;
				bad_nxt = 1'b0;
				over_nxt = 1'b0;
				acc_nxt = 20'h00000;
				idx_nxt = 5'h00;
				if (nTok != 2'h0) begin
					state_nxt = icp_pkg::ST_LF1;
					kind_nxt = icp_pkg::KIND_FAIL;
					if (bad_r || tok0Short) begin
						errCode_nxt = `ICP_ERR_SYNTAX;
					end else if (nTok == 2'h1) begin
						kind_nxt = icp_pkg::KIND_OK;
					end else if (nTok == 2'h2) begin
						errCode_nxt = `ICP_ERR_MISSING_ARG;
					end else if (over_r) begin
						errCode_nxt = `ICP_ERR_RANGE;
					end else begin
						kind_nxt = icp_pkg::KIND_INFO;
						sel_nxt = acc_r[15:0];
					end
					if (kind_nxt == icp_pkg::KIND_FAIL) begin
						lastErr_nxt = errCode_nxt;
					end
				end
			end else if (rxData == `ICP_CH_LF) begin
				// stray linefeeds from terminals are dropped
				tokLen_nxt = tokLen_r;
			end else if (rxData == `ICP_CH_SPACE) begin
				if (tokLen_r != 3'h0) begin
					bad_nxt = bad_r || tok0Short;
					tokIdx_nxt = (tokIdx_r == 2'h3) ? 2'h3 : tokIdx_r + 2'h1;
					tokLen_nxt = 3'h0;
				end
			end else begin
				tokLen_nxt = (tokLen_r == 3'h7) ? 3'h7 : tokLen_r + 3'h1;
				unique case (tokIdx_r)
					2'h0: begin
						// prefix token is exactly the two letters
						if (!((tokLen_r == 3'h0) && isA) && !((tokLen_r == 3'h1) && isT)) begin
							bad_nxt = 1'b1;
						end
					end
					2'h1: begin
						if (!((tokLen_r == 3'h0) && isI)) begin
							bad_nxt = 1'b1;
						end
					end
					2'h2: begin
						if (!isDigit) begin
							bad_nxt = 1'b1;
						end else if (tokLen_r >= `ICP_ECHO_MAX) begin
							// echo buffer limits the digit count
							over_nxt = 1'b1;
						end else begin
							echo_nxt[tokLen_r] = rxData;
							echoLen_nxt = tokLen_r + 3'h1;
							acc_nxt = accMul + {12'h000, rxData - `ICP_CH_ZERO};
							if ((accMul + {12'h000, rxData - `ICP_CH_ZERO}) > `ICP_SEL_MAX) begin
								over_nxt = 1'b1;
							end
						end
					end
					2'h3: bad_nxt = 1'b1;
				endcase
			end
		end else if ((state_r != icp_pkg::ST_RECV) && loadSlot) begin
			// one reply byte per free output slot
			txData_nxt = curByte;
			txValid_nxt = 1'b1;
			idx_nxt = 5'h00;
			unique case (state_r)
				icp_pkg::ST_RECV: state_nxt = icp_pkg::ST_RECV;
				icp_pkg::ST_LF1: state_nxt = icp_pkg::ST_STAT;
				icp_pkg::ST_STAT: begin
					if (idx_r == 5'h00) begin
						idx_nxt = 5'h01;
					end else if (kind_r == icp_pkg::KIND_OK) begin
						state_nxt = icp_pkg::ST_CR1;
					end else begin
						state_nxt = icp_pkg::ST_TAB1;
					end
				end
				icp_pkg::ST_TAB1: begin
					state_nxt = (kind_r == icp_pkg::KIND_FAIL) ? icp_pkg::ST_HEX : icp_pkg::ST_ECHO;
				end
				icp_pkg::ST_ECHO: begin
					idx_nxt = idx_r + 5'h01;
					if (idx_r + 5'h01 >= {2'h0, echoLen_r}) begin
						idx_nxt = 5'h00;
						state_nxt = icp_pkg::ST_TAB2;
					end
				end
				icp_pkg::ST_TAB2: state_nxt = icp_pkg::ST_INFO;
				icp_pkg::ST_INFO: begin
					idx_nxt = idx_r + 5'h01;
					if (idx_r + 5'h01 >= infoLen) begin
						idx_nxt = 5'h00;
						state_nxt = icp_pkg::ST_CR1;
					end
				end
				icp_pkg::ST_HEX: begin
					// no tab or text follows the code
					idx_nxt = 5'h01;
					if (idx_r != 5'h00) begin
						idx_nxt = 5'h00;
						state_nxt = icp_pkg::ST_CR1;
					end
				end
				icp_pkg::ST_CR1: begin
					state_nxt = (kind_r == icp_pkg::KIND_INFO) ? icp_pkg::ST_LF2 : icp_pkg::ST_RECV;
				end
				icp_pkg::ST_LF2: state_nxt = icp_pkg::ST_OK;
				icp_pkg::ST_OK: begin
					idx_nxt = 5'h01;
					if (idx_r != 5'h00) begin
						idx_nxt = 5'h00;
						state_nxt = icp_pkg::ST_CR2;
					end
				end
				icp_pkg::ST_CR2: state_nxt = icp_pkg::ST_RECV;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= icp_pkg::ST_RECV;
			kind_r <= icp_pkg::KIND_OK;
			idx_r <= 5'h00;
			tokIdx_r <= 2'h0;
			tokLen_r <= 3'h0;
			bad_r <= 1'b0;
			over_r <= 1'b0;
			acc_r <= 20'h00000;
			echo_r <= '{default: 8'h00};
			echoLen_r <= 3'h0;
			sel_r <= 16'h0000;
			errCode_r <= 8'h00;
			lastErr_r <= 8'h00;
			txData_r <= 8'h00;
			txValid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			idx_r <= idx_nxt;
			tokIdx_r <= tokIdx_nxt;
			tokLen_r <= tokLen_nxt;
			bad_r <= bad_nxt;
			over_r <= over_nxt;
			acc_r <= acc_nxt;
			echo_r <= echo_nxt;
			echoLen_r <= echoLen_nxt;
			sel_r <= sel_nxt;
			errCode_r <= errCode_nxt;
			lastErr_r <= lastErr_nxt;
			txData_r <= txData_nxt;
			txValid_r <= txValid_nxt;
		end
	end

endmodule : interactive_command_port

// *** dv/interactive_command_port_chk.sv ***
// concurrent checks on the reply stream of the command port
`timescale 1ns/1ps
`include "icp_consts.svh"

module interactive_command_port_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic lowPower
);
	localparam logic [7:0] LF = `ICP_CH_LF;
	localparam logic [7:0] TB = `ICP_CH_TAB;
	localparam logic [7:0] CR = `ICP_CH_CR;
	logic [47:0] hist_r;
	logic [47:0] hist_nxt;
	logic txAcc;
	logic crAcc;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////////////////
	// last six accepted reply bytes, newest low; lets line patterns be matched
	assign txAcc = txValid && txReady;
	assign crAcc = rxValid && rxReady && rxData == CR;
	always_comb begin
		hist_nxt = hist_r;
		if (txAcc) begin
			hist_nxt = {hist_r[39:0], txData};
		end
	end
	always_ff @(posedge clk) begin
		hist_r <= resetn ? hist_nxt : '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// framing and status line checks
	txHold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("reply byte changed before acceptance");
	idlePower_a: assert property (lowPower == (rxReady && !rxValid && !txValid))
		else $error("low power flag disagrees with idle state");
	firstByte_a: assert property ($rose(txValid) && ($past(crAcc) || $past(crAcc, 2)
		|| $past(crAcc, 3)) |-> txData == LF && !rxReady)
		else $error("reply did not open with a linefeed");
	statusDigit_a: assert property (txAcc && txData == LF |=> txValid
		&& txData inside {8'h30, 8'h31})
		else $error("status field is not two decimal digits");
	okEnd_a: assert property (txAcc && hist_r[23:0] == {LF, 16'h3030} |-> txData == CR)
		else $error("success line holds more than 00");
	failTab_a: assert property (txAcc && hist_r[23:0] == {LF, 16'h3031} |-> txData == TB)
		else $error("failure status not followed by a tab");
	infoTab_a: assert property (txAcc && hist_r[23:0] == {LF, 16'h3130} |-> txData == TB)
		else $error("information status not followed by a tab");
	hexField_a: assert property (txAcc && hist_r[39:8] == {LF, 16'h3031, TB}
		|-> txData inside {[8'h30:8'h39], [8'h41:8'h46]})
		else $error("error code is not a hex digit");
	failEnd_a: assert property (txAcc && hist_r[47:16] == {LF, 16'h3031, TB}
		|-> txData == CR)
		else $error("failure line carries extra text");
	replyDone_a: assert property (txAcc && txData == CR && (hist_r[23:0] == {LF, 16'h3030}
		|| hist_r[47:16] == {LF, 16'h3031, TB}) |=> rxReady && !txValid)
		else $error("port not ready after the final line");

	okSeen_c: cover property (txAcc && txData == CR && hist_r[23:0] == {LF, 16'h3030});
	failSeen_c: cover property (txAcc && hist_r[47:16] == {LF, 16'h3031, TB});
	stallSeen_c: cover property (txValid && !txReady ##1 txAcc);
endmodule : interactive_command_port_chk

bind interactive_command_port interactive_command_port_chk chk_u (.clk(clk), .resetn(resetn),
	.rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
	.txValid(txValid), .txReady(txReady), .lowPower(lowPower));

// *** dv/host_model.sv ***
// host side model: takes reply bytes, stalling at random when asked
`timescale 1ns/1ps

module host_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic stallEn,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady
);
	string got;
	int seed;

	initial begin
		seed = 32'h28fddb3d;
		got = "";
		txReady = 1'b1;
	end
	// ready moves only at the falling edge, clear of the sampling edge
	always @(negedge clk) begin
		txReady <= !stallEn || ($random(seed) % 3 != 0);
	end
	// keep each byte on the edge that accepts it
	always @(posedge clk) begin
		if (resetn && txValid && txReady) begin
			got = {got, $sformatf("%c", txData)};
		end
	end
endmodule : host_model

// *** dv/interactive_command_port_tb.sv ***
// self-checking bench for the command port
`timescale 1ns/1ps

module interactive_command_port_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] rxData = 8'h00;
	logic rxValid = 1'b0;
	logic rxReady;
	logic [7:0] txData;
	logic txValid;
	logic txReady;
	logic [1:0] addrType = 2'h0;
	logic [47:0] macAddr = 48'h0;
	logic [15:0] st [6] = '{default: 16'h0};
	logic lowPower;
	logic stallEn = 1'b0;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int seed = 32'h28fddb3d;
	int lastErr = 0;
	int sels [8] = '{0, 3, 4, 5, 6, 7, 12, 65535};

	interactive_command_port dut_u (.clk(clk), .resetn(resetn), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid),
		.txReady(txReady), .addrType(addrType), .macAddr(macAddr), .dataTotal(st[0]),
		.dataFree(st[1]), .dataDeleted(st[2]), .fatTotal(st[3]), .fatFree(st[4]),
		.fatDeleted(st[5]), .lowPower(lowPower));
	host_model host_u (.clk(clk), .resetn(resetn), .stallEn(stallEn), .txData(txData),
		.txValid(txValid), .txReady(txReady));

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard; a stuck reply would otherwise run forever
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic check(input string name, input string seen, input string exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %s seen %s", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// one byte offered and held until the port is ready at a rising edge
	task automatic putByte(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge clk);
		rxData = b;
		rxValid = 1'b1;
		while (!rxReady && n < 100) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
	endtask : putByte

	// released line shows the inverse of the last byte, never a stale copy
	task automatic idle();
		@(negedge clk);
		rxValid = 1'b0;
		rxData = ~rxData;
	endtask : idle

	// whole command line, then wait for the final line before the next one
	task automatic run(input string cmd, input string exp);
		int n;
		n = 0;
		host_u.got = "";
		foreach (cmd[i]) putByte(cmd[i]);
		putByte(8'h0d);
		idle();
		while (!(rxReady && !txValid) && n < 3000) begin
			@(negedge clk);
			n++;
		end
		check(cmd, host_u.got, exp);
	endtask : run

	function automatic string fail(input int code);
		string t;
		lastErr = code;
		t = $sformatf("\n01\t%02h\r", code[7:0]);
		return t.toupper();
	endfunction : fail

	function automatic string info(input string echo, input int sel);
		string t;
		case (sel)
			0: t = "ICPDEV01";
			3: t = "1.0.0.00";
			4: t = $sformatf("0%0d %012h", addrType, macAddr);
			5: t = "CHIPSET0";
			6: t = $sformatf("%04h.%04h.%04h", st[0], st[1], st[2]);
			7: t = $sformatf("%04h.%04h.%04h", st[3], st[4], st[5]);
			12: t = $sformatf("%02h", lastErr[7:0]);
			default: t = "MAKERNAM";
		endcase
		t = t.toupper();
		return {"\n10\t", echo, "\t", t, "\r\n00\r"};
	endfunction : info

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		check("idle", $sformatf("%b%b%b", rxReady, txValid, lowPower), "101");
		run("AT", "\n00\r");
		run("at", "\n00\r");
		run("  ", "");
		// a line without its carriage return stays silent
		putByte("A");
		putByte("T");
		idle();
		repeat (10) @(negedge clk);
		check("partial", $sformatf("%b", txValid), "0");
		run("", "\n00\r");
		stallEn = 1'b1;
		run("ATI", fail(1));
		run("AT I", fail(2));
		run("AT I 65536", fail(3));
		run("AT I 123456", fail(3));
		run("AT X 1", fail(1));
		run("AT I 7 7", fail(1));
		run("AT  I   00005", info("00005", 5));
		// every address type code, then defined and random selectors
		for (int t = 0; t < 4; t++) begin
			addrType = 2'(t);
			macAddr = {16'($random(seed)), 32'($random(seed))};
			run("AT i 4", info("4", 4));
		end
		for (int k = 0; k < 14; k++) begin
			int s;
			s = k < 8 ? sels[k] : ($random(seed) & 32'h0000ffff);
			foreach (st[j]) st[j] = 16'($random(seed));
			run($sformatf("AT I %0d", s), info($sformatf("%0d", s), s));
		end
		final_report();
	end
endmodule : interactive_command_port_tb
